// *** design/ncsi_cmd_if.sv ***
/*
 * Command/status register interface of the nonvolatile memory
 * programming controller: two byte-wide command data ports (processor
 * and DMA) and a status register on an Avalon-MM slave, a key checker
 * and a byte forwarder to the command engine, and a two-entry response
 * buffer. Assumes the engine answers with response bytes and one done
 * pulse per command, all on core_clk.
 */
// Overview of operation
// - Two 8-bit data ports, processor and DMA, take commands as byte writes.
// - Response bytes are read only from the port that sent the command.
// - An 8-bit status register shows idle, data ready and exit code.
// - Idle clears as soon as first key byte 0xB6 is written.
// - Idle sets again when a command finishes or an error is found.
// - While busy, command bytes to either port start nothing new.
// - Every command starts with key byte 0xB6, checked by the device.
// - Second key equals 0xD3 plus command code, low eight bits kept.
// - Keys, then command code, then parameter bytes, then data bytes.
// - Status bit 0 is set while a response byte waits to be read.
// - Exit code sits in bits 7:2; 0x00 success, 0x02 bad key.
// - A bad second key returns idle to one and drops the command.

`timescale 1ns/1ns
`default_nettype none

module ncsi_cmd_if (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire ncsi_pkg::ncsi_avm_req_t avm_req,
    output logic [31:0] avm_readdata,
    output logic avm_waitrequest,
    // Command engine side
    output ncsi_pkg::ncsi_eng_req_t eng_req,
    input wire ncsi_pkg::ncsi_eng_rsp_t eng_rsp,
    output logic eng_rsp_ready,
    input wire ncsi_pkg::ncsi_eng_done_t eng_done
);
    import ncsi_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ncsi_state_t fsm;
        ncsi_port_t owner;
        logic [7:0] key2;
        logic idle;
        logic [5:0] code;
        logic waitreq;
        logic [31:0] rdata;
        ncsi_eng_req_t eng;
    } ncsi_cmd_st_t;

    localparam ncsi_cmd_st_t ST_RST = '{
        fsm: NCSI_S_IDLE,
        owner: NCSI_PORT_CPU,
        key2: 8'h00,
        idle: NCSI_IDLE_RST,
        code: NCSI_CODE_RST,
        waitreq: NCSI_WAITREQ_RST,
        rdata: 32'h0000_0000,
        eng: '0
    };

    ncsi_cmd_st_t st_r;
    ncsi_cmd_st_t st_nxt;

    logic req;
    logic commit;
    logic is_data;
    ncsi_port_t port;
    logic own_port;
    logic wr_byte;
    logic own_wr;
    logic [7:0] wbyte;
    logic [7:0] key2_expect;
    logic [7:0] status;
    logic buf_valid;
    logic [7:0] buf_data;
    logic buf_pop;
    logic buf_flush;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------

    // Request is taken at the edge where waitrequest is seen low
    assign req = avm_req.read || avm_req.write;
    assign commit = req && !st_r.waitreq;
    assign is_data = (avm_req.address == NCSI_IDX_CPU_DATA) ||
                     (avm_req.address == NCSI_IDX_DMA_DATA);
    assign port = (avm_req.address == NCSI_IDX_DMA_DATA) ? NCSI_PORT_DMA : NCSI_PORT_CPU;
    assign own_port = is_data && (port == st_r.owner);
    assign wbyte = avm_req.writedata[7:0];
    // Only the low byte lane carries a command byte
    assign wr_byte = commit && avm_req.write && avm_req.byteenable[0] && is_data;
    assign own_wr = wr_byte && (port == st_r.owner);
    assign key2_expect = 8'(wbyte + NCSI_KEY2_BASE);

    // Status image: code, idle, data ready
    always_comb begin
        status = 8'h00;
        status[NCSI_SR_READY_BIT] = buf_valid;
        status[NCSI_SR_IDLE_BIT] = st_r.idle;
        status[7:NCSI_SR_CODE_LSB] = st_r.code;
    end

    // Read of the owner port consumes one response byte
    assign buf_pop = commit && avm_req.read && own_port && buf_valid;
    assign buf_flush = st_r.idle && wr_byte && (wbyte == NCSI_KEY1);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    // Bus answer, key checking and byte forwarding
    always_comb begin
        st_nxt = st_r;
        st_nxt.eng = '0;
        // One wait cycle, then answer; read data prepared meanwhile
        if (req && st_r.waitreq) begin
            st_nxt.waitreq = 1'b0;
            st_nxt.rdata = 32'h0000_0000;
            if (avm_req.address == NCSI_IDX_STATUS) begin
                st_nxt.rdata = {24'h00_0000, status};
            end else if (own_port && buf_valid) begin
                st_nxt.rdata = {24'h00_0000, buf_data};
            end
        end
        if (commit) begin
            st_nxt.waitreq = 1'b1;
        end
        unique case (st_r.fsm)
            NCSI_S_IDLE: begin
                // Only a first key starts a command; anything else is dropped
                if (wr_byte && (wbyte == NCSI_KEY1)) begin
                    st_nxt.fsm = NCSI_S_KEY2;
                    st_nxt.idle = 1'b0;
                    st_nxt.owner = port;
                end
            end
            NCSI_S_KEY2: begin
                if (own_wr) begin
                    st_nxt.key2 = wbyte;
                    st_nxt.fsm = NCSI_S_CODE;
                end
            end
            NCSI_S_CODE: begin
                if (own_wr) begin
                    if (key2_expect == st_r.key2) begin
                        st_nxt.eng = '{valid: 1'b1, is_code: 1'b1, data: wbyte};
                        st_nxt.fsm = NCSI_S_BODY;
                    end else begin
                        st_nxt.code = NCSI_CODE_BAD_KEY;
                        st_nxt.idle = 1'b1;
                        st_nxt.fsm = NCSI_S_IDLE;
                    end
                end
            end
            NCSI_S_BODY: begin
                // Parameter and data bytes pass on in arrival order
                if (own_wr) begin
                    st_nxt.eng = '{valid: 1'b1, is_code: 1'b0, data: wbyte};
                end
                if (eng_done.done) begin
                    st_nxt.code = eng_done.code;
                    st_nxt.idle = 1'b1;
                    st_nxt.fsm = NCSI_S_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Response buffer
    // ----------------------------------------------------------------

    // A stall by the reader holds the engine through eng_rsp_ready
    ncsi_rsp_buf #(
        .W(NCSI_BYTE_W),
        .DEPTH(NCSI_RSP_DEPTH)
    ) u_rsp_buf (
        .core_clk(core_clk),
        .resetn(resetn),
        .flush(buf_flush),
        .in_valid(eng_rsp.valid),
        .in_data(eng_rsp.data),
        .in_ready(eng_rsp_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(buf_pop)
    );

    // Outputs from the state register
    assign avm_readdata = st_r.rdata;
    assign avm_waitrequest = st_r.waitreq;
    assign eng_req = st_r.eng;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_wait_one;
        req && avm_waitrequest;
    endsequence

    sequence s_answer;
        !avm_waitrequest ##1 avm_waitrequest;
    endsequence

    property p_bus_answer;
        s_wait_one |=> s_answer;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not one cycle after the request");

    property p_key1_clears_idle;
        (st_r.idle && wr_byte && wbyte == NCSI_KEY1) |=> !status[NCSI_SR_IDLE_BIT];
    endproperty
    a_key1_clears_idle: assert property (p_key1_clears_idle)
        else $error("idle not cleared by first key");

    property p_busy_other_port;
        (!st_r.idle && wr_byte && port != st_r.owner && !eng_done.done)
            |=> ($stable(st_r.fsm) && $stable(st_r.code) && $stable(st_r.key2));
    endproperty
    a_busy_other_port: assert property (p_busy_other_port)
        else $error("busy write on the other port changed the command");

    property p_busy_no_restart;
        (!st_r.idle && wr_byte && wbyte == NCSI_KEY1 && st_r.fsm == NCSI_S_BODY &&
         !eng_done.done) |=> (st_r.fsm == NCSI_S_BODY && !st_r.idle);
    endproperty
    a_busy_no_restart: assert property (p_busy_no_restart)
        else $error("first key restarted a running command");

    property p_bad_key;
        (st_r.fsm == NCSI_S_CODE && own_wr && key2_expect != st_r.key2)
            |=> (st_r.idle && st_r.code == NCSI_CODE_BAD_KEY && !eng_req.valid);
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("bad second key not reported");

    property p_good_key;
        (st_r.fsm == NCSI_S_CODE && own_wr && key2_expect == st_r.key2)
            |=> (eng_req.valid && eng_req.is_code && eng_req.data == $past(wbyte));
    endproperty
    a_good_key: assert property (p_good_key)
        else $error("valid command code not forwarded");

    property p_done_idle;
        (st_r.fsm == NCSI_S_BODY && eng_done.done)
            |=> (st_r.idle && st_r.code == $past(eng_done.code));
    endproperty
    a_done_idle: assert property (p_done_idle)
        else $error("finished command did not return to idle");

    property p_status_read;
        (s_wait_one and (avm_req.read && avm_req.address == NCSI_IDX_STATUS))
            |=> (avm_readdata[7:0] == $past(status) && avm_readdata[31:8] == 24'h00_0000);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read returned the wrong image");

    property p_other_port_zero;
        (s_wait_one and (avm_req.read && is_data && port != st_r.owner))
            |=> (avm_readdata == 32'h0000_0000);
    endproperty
    a_other_port_zero: assert property (p_other_port_zero)
        else $error("response leaked through the other port");

    property p_ready_bit;
        (s_wait_one and (avm_req.read && avm_req.address == NCSI_IDX_STATUS))
            |=> (avm_readdata[NCSI_SR_READY_BIT] == $past(buf_valid));
    endproperty
    a_ready_bit: assert property (p_ready_bit)
        else $error("data ready bit does not follow the buffer");

endmodule : ncsi_cmd_if

`default_nettype wire

// *** inc/ncsi_pkg.sv ***
/*
 * Shared definitions of the command/status interface: register word
 * indices, status field layout, key values, exit codes, reset values
 * and the packed carriers that join the interface to its engine.
 * Assumes one clock domain and a word-addressed Avalon-MM slave port.
 */

`default_nettype none

package ncsi_pkg;

    // ----------------------------------------------------------------
    // Register map (word index on the Avalon address)
    // ----------------------------------------------------------------
    localparam logic [1:0] NCSI_IDX_CPU_DATA = 2'h0;
    localparam logic [1:0] NCSI_IDX_DMA_DATA = 2'h1;
    localparam logic [1:0] NCSI_IDX_STATUS = 2'h2;

    // ----------------------------------------------------------------
    // Status register layout and reset values
    // ----------------------------------------------------------------
    localparam int NCSI_SR_READY_BIT = 0;
    localparam int NCSI_SR_IDLE_BIT = 1;
    localparam int NCSI_SR_CODE_LSB = 2;
    localparam logic NCSI_IDLE_RST = 1'b1;
    localparam logic [5:0] NCSI_CODE_RST = 6'h00;
    localparam logic NCSI_WAITREQ_RST = 1'b1;

    // ----------------------------------------------------------------
    // Command keys and exit codes
    // ----------------------------------------------------------------
    localparam logic [7:0] NCSI_KEY1 = 8'hB6;
    localparam logic [7:0] NCSI_KEY2_BASE = 8'hD3;
    localparam logic [5:0] NCSI_CODE_OK = 6'h00;
    localparam logic [5:0] NCSI_CODE_BAD_KEY = 6'h02;

    // ----------------------------------------------------------------
    // Response buffer shape
    // ----------------------------------------------------------------
    localparam int NCSI_RSP_DEPTH = 2;
    localparam int NCSI_BYTE_W = 8;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        NCSI_S_IDLE,
        NCSI_S_KEY2,
        NCSI_S_CODE,
        NCSI_S_BODY
    } ncsi_state_t;

    typedef enum logic {
        NCSI_PORT_CPU,
        NCSI_PORT_DMA
    } ncsi_port_t;

    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } ncsi_avm_req_t;

    // Byte forwarded to the engine; is_code marks the command code
    typedef struct packed {
        logic valid;
        logic is_code;
        logic [7:0] data;
    } ncsi_eng_req_t;

    // Response byte from the engine
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ncsi_eng_rsp_t;

    // End of command with its exit code
    typedef struct packed {
        logic done;
        logic [5:0] code;
    } ncsi_eng_done_t;

endpackage : ncsi_pkg

`default_nettype wire

// *** design/ncsi_rsp_buf.sv ***
/*
 * Small flip-flop FIFO with valid/ready on both sides and a flush.
 * Assumes the drain side may stall at will; in_ready is registered.
 */

`timescale 1ns/1ns
`default_nettype none

module ncsi_rsp_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Control
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    import ncsi_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [CW-1:0] cnt;
        logic in_ready;
    } ncsi_buf_st_t;

    ncsi_buf_st_t st_r;
    ncsi_buf_st_t st_nxt;
    logic push;
    logic pop;

    // Handshakes on both sides
    assign push = in_valid && st_r.in_ready;
    assign pop = out_ready && (st_r.cnt != '0);
    assign in_ready = st_r.in_ready;
    assign out_valid = (st_r.cnt != '0);
    assign out_data = st_r.mem[st_r.rd];

    // Next state: write per entry, move pointers, track fill level
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < DEPTH; i++) begin
            if (push && (st_r.wr == PW'(i))) begin
                st_nxt.mem[i] = in_data;
            end
        end
        if (push) begin
            st_nxt.wr = (st_r.wr == LAST) ? '0 : PW'(st_r.wr + 1'b1);
        end
        if (pop) begin
            st_nxt.rd = (st_r.rd == LAST) ? '0 : PW'(st_r.rd + 1'b1);
        end
        st_nxt.cnt = CW'(st_r.cnt + CW'(push) - CW'(pop));
        if (flush) begin
            st_nxt.rd = '0;
            st_nxt.wr = '0;
            st_nxt.cnt = '0;
        end
        st_nxt.in_ready = (st_nxt.cnt != FULL);
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_r <= '{mem: '0, rd: '0, wr: '0, cnt: '0, in_ready: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : ncsi_rsp_buf

`default_nettype wire

// *** dv/ncsi_eng_model.sv ***
/*
 * Behavioural command engine standing behind the command interface.
 * After the code byte it takes one parameter byte p, ends the command
 * with exit code p[5:0] and offers four response bytes p to p+3,
 * a result word sent least significant byte first.
 * Assumes the interface forwards bytes as one-cycle pulses on core_clk.
 */

`timescale 1ns/1ns
`default_nettype none

module ncsi_eng_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Pacing: slow delays the first response byte
    input wire logic slow,
    // From the interface
    input wire ncsi_pkg::ncsi_eng_req_t eng_req,
    input wire logic eng_rsp_ready,
    // To the interface
    output ncsi_pkg::ncsi_eng_rsp_t eng_rsp,
    output ncsi_pkg::ncsi_eng_done_t eng_done
);
    import ncsi_pkg::*;

    logic have_code_r;
    logic [7:0] param_r;
    logic [2:0] left_r;
    logic [2:0] delay_r;

    // ------------------------------------------------------------
    // Command intake and response stream
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            have_code_r <= 1'b0;
            param_r <= 8'h00;
            left_r <= 3'h0;
            delay_r <= 3'h0;
            eng_rsp <= '0;
            eng_done <= '0;
        end else begin
            eng_done <= '0;
            if (delay_r != 3'h0) begin
                delay_r <= delay_r - 3'h1;
                if (delay_r == 3'h1) begin
                    eng_rsp <= {1'b1, param_r};
                end
            end else if (eng_rsp.valid && eng_rsp_ready) begin
                // Byte taken: move on, drop valid after the last
                left_r <= left_r - 3'h1;
                eng_rsp.data <= eng_rsp.data + 8'h01;
                if (left_r == 3'h1) begin
                    eng_rsp.valid <= 1'b0;
                end
            end else if (!eng_rsp.valid) begin
                // Idle data keeps moving so stale bytes never look valid
                eng_rsp.data <= ~eng_rsp.data;
            end
            if (eng_req.valid && eng_req.is_code) begin
                have_code_r <= 1'b1;
            end
            if (eng_req.valid && !eng_req.is_code && have_code_r) begin
                have_code_r <= 1'b0;
                param_r <= eng_req.data;
                left_r <= 3'h4;
                delay_r <= slow ? 3'h6 : 3'h1;
                eng_done <= {1'b1, eng_req.data[5:0]};
            end
        end
    end

endmodule : ncsi_eng_model

`default_nettype wire

// *** dv/nvm_command_status_interface_tb.sv ***
/*
 * Self-checking bench of the command interface: Avalon-MM read and
 * write tasks, key checks, busy discard, response buffer and status.
 * Assumes the engine model of this folder and the shared package.
 */

`timescale 1ns/1ns
`default_nettype none

module nvm_command_status_interface_tb;
    import ncsi_pkg::*;

    logic core_clk;
    logic resetn;
    ncsi_avm_req_t avm_req;
    logic [31:0] avm_readdata;
    logic avm_waitrequest;
    ncsi_eng_req_t eng_req;
    ncsi_eng_rsp_t eng_rsp;
    logic eng_rsp_ready;
    ncsi_eng_done_t eng_done;
    logic slow;
    int failures;
    int checks;
    int cycles;
    int nreq;
    int n0;
    logic [7:0] got_code;
    logic [5:0] last_code;
    logic [31:0] rd;

    // ------------------------------------------------------------
    // Design and engine
    // ------------------------------------------------------------
    ncsi_cmd_if dut (
        .core_clk(core_clk), .resetn(resetn), .avm_req(avm_req),
        .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
        .eng_req(eng_req), .eng_rsp(eng_rsp), .eng_rsp_ready(eng_rsp_ready),
        .eng_done(eng_done)
    );
    ncsi_eng_model eng (
        .core_clk(core_clk), .resetn(resetn), .slow(slow), .eng_req(eng_req),
        .eng_rsp_ready(eng_rsp_ready), .eng_rsp(eng_rsp), .eng_done(eng_done)
    );

    // Clock of 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Forwarded byte log and run-time ceiling
    always @(posedge core_clk) begin
        cycles++;
        if (eng_req.valid === 1'b1) begin
            nreq++;
            if (eng_req.is_code === 1'b1) begin
                got_code = eng_req.data;
            end
        end
        if (cycles >= 20000) begin
            failures++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task final_report;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One Avalon access, held until waitrequest is sampled low
    task bus(input logic rd_en, input logic [1:0] addr, input logic [7:0] wd,
             input logic [3:0] be, output logic [31:0] data);
        @(posedge core_clk);
        avm_req.read <= rd_en;
        avm_req.write <= !rd_en;
        avm_req.address <= addr;
        avm_req.writedata <= {24'h000000, wd};
        avm_req.byteenable <= be;
        do @(posedge core_clk); while (avm_waitrequest !== 1'b0);
        data = avm_readdata;
        avm_req.read <= 1'b0;
        avm_req.write <= 1'b0;
    endtask : bus

    task wr(input logic [1:0] addr, input logic [7:0] wd);
        bus(1'b0, addr, wd, 4'hF, rd);
    endtask : wr

    task rdchk(input logic [1:0] addr, input logic [7:0] exp);
        bus(1'b1, addr, 8'h00, 4'hF, rd);
        chk(rd, {24'h000000, exp});
    endtask : rdchk

    function automatic logic [7:0] st(input logic [5:0] code, input logic idle,
                                      input logic rdy);
        st = {code, idle, rdy};
    endfunction : st

    // Full keyed command with a four-byte result word read back
    task run_cmd(input logic [1:0] port, input logic [7:0] code, input logic [7:0] p);
        int k;
        logic [31:0] resp;
        n0 = nreq;
        rdchk(NCSI_IDX_STATUS, st(last_code, 1'b1, 1'b0));
        wr(port, NCSI_KEY1);
        rdchk(NCSI_IDX_STATUS, st(last_code, 1'b0, 1'b0));
        wr(port ^ 2'h1, NCSI_KEY1);
        rdchk(NCSI_IDX_STATUS, st(last_code, 1'b0, 1'b0));
        wr(port, NCSI_KEY2_BASE + code);
        wr(port, code);
        // First key on the other port while the command body runs
        wr(port ^ 2'h1, NCSI_KEY1);
        wr(port, p);
        // Let the last forwarded pulse reach the log before counting
        repeat (2) @(posedge core_clk);
        chk(32'(nreq - n0), 32'h2);
        chk({24'h000000, got_code}, {24'h000000, code});
        k = 0;
        while (eng_rsp_ready !== 1'b0 && k < 200) begin
            @(posedge core_clk);
            k++;
        end
        chk({31'h0, eng_rsp_ready}, 32'h0);
        rdchk(NCSI_IDX_STATUS, st(p[5:0], 1'b1, 1'b1));
        rdchk(port ^ 2'h1, 8'h00);
        for (k = 0; k < 4; k++) begin
            rdchk(port, 8'(p + k));
            resp = {rd[7:0], resp[31:8]};
        end
        // Result word as a programmer rebuilds it, low byte first
        chk(resp, {p + 8'h03, p + 8'h02, p + 8'h01, p});
        // Only the low half is held against the first two bytes, first byte in the low byte
        chk({16'h0000, resp[15:0]}, {16'h0000, p + 8'h01, p});
        rdchk(NCSI_IDX_STATUS, st(p[5:0], 1'b1, 1'b0));
        rdchk(port, 8'h00);
        last_code = p[5:0];
    endtask : run_cmd

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        slow = 1'b0;
        avm_req = '0;
        failures = 0;
        checks = 0;
        cycles = 0;
        nreq = 0;
        got_code = 8'h00;
        last_code = NCSI_CODE_RST;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        rdchk(NCSI_IDX_STATUS, st(NCSI_CODE_RST, NCSI_IDLE_RST, 1'b0));
        // Non-key byte and disabled byte lane leave the port idle
        wr(NCSI_IDX_CPU_DATA, 8'h55);
        rdchk(NCSI_IDX_STATUS, 8'h02);
        bus(1'b0, NCSI_IDX_CPU_DATA, NCSI_KEY1, 4'hE, rd);
        rdchk(NCSI_IDX_STATUS, 8'h02);
        // Unmapped word and read-only status
        wr(2'h3, NCSI_KEY1);
        rdchk(2'h3, 8'h00);
        wr(NCSI_IDX_STATUS, 8'hFF);
        rdchk(NCSI_IDX_STATUS, 8'h02);
        // Wrong second key aborts with nothing forwarded
        n0 = nreq;
        wr(NCSI_IDX_CPU_DATA, NCSI_KEY1);
        wr(NCSI_IDX_CPU_DATA, NCSI_KEY2_BASE + 8'h11);
        wr(NCSI_IDX_CPU_DATA, 8'h10);
        rdchk(NCSI_IDX_STATUS, st(NCSI_CODE_BAD_KEY, 1'b1, 1'b0));
        chk(32'(nreq - n0), 32'h0);
        last_code = NCSI_CODE_BAD_KEY;
        // Key sum wraps past 0xFF on the DMA port, then a slow CPU command
        run_cmd(NCSI_IDX_DMA_DATA, 8'h40, 8'h05);
        slow <= 1'b1;
        run_cmd(NCSI_IDX_CPU_DATA, 8'h21, 8'h00);
        final_report();
    end

endmodule : nvm_command_status_interface_tb

`default_nettype wire
